// ===== dpau_defines.svh
// Purpose: constants for the dual pointer address unit
// Assumes: 8-bit register port, 16-bit pointers
// Notes:   offsets are register-port addresses
`ifndef DPAU_DEFINES_SVH
`define DPAU_DEFINES_SVH

// register offsets
`define OFS_POINTER_CONFIG      8'hA2
`define OFS_CIRCULAR_LENGTH     8'hE3
`define OFS_SIGNAL_PROC_CONFIG  8'hE2
`define OFS_PTR0_LOW            8'hC4
`define OFS_PTR0_HIGH           8'hC5
`define OFS_PTR1_LOW            8'hC6
`define OFS_PTR1_HIGH           8'hC7

// pointer_config fields
`define BIT_PTR1_AUTO_UPDATE    7
`define BIT_PTR0_AUTO_UPDATE    6
`define BIT_PTR1_DECREMENT      5
`define BIT_PTR0_DECREMENT      4
`define BIT_SIGNATURE_SPACE     3
`define BIT_POINTER_SELECT      0
`define MASK_POINTER_CONFIG     8'hF9

// signal_processing_config fields
`define BIT_PTR1_CIRCULAR       3
`define BIT_PTR0_CIRCULAR       2
`define BIT_CODE_INDEX_DISABLE  1
`define BIT_REDIRECT_TO_B       0
`define MASK_SIGNAL_PROC_CONFIG 8'h0F

// reset values
`define RST_POINTER_CONFIG      8'h00
`define RST_SIGNAL_PROC_CONFIG  8'h00
`define RST_CIRCULAR_LENGTH     8'h00
`define RST_POINTER             16'h0000

// circular region bases (high byte of the region)
`define REGION_A_HIGH           8'h00
`define REGION_B_HIGH           8'h01

`endif

// ===== dpau_pkg.sv
// Purpose: shared types for the dual pointer address unit
// Assumes: decoder issues one operation per cycle
// Notes:   operation codes are the decoder's pointer requests
package dpau_pkg;

    // pointer operation requested by the instruction decoder
    typedef enum logic [2:0] {
        OP_LOAD  = 3'h0,   // load 16-bit immediate
        OP_INC   = 3'h1,   // pointer increment instruction
        OP_XRD   = 3'h2,   // external-data read through pointer
        OP_XWR   = 3'h3,   // external-data write through pointer
        OP_CRD   = 3'h4,   // indexed code read through pointer
        OP_JMP   = 3'h5    // indirect jump, accumulator plus pointer
    } op_e;

    typedef logic [15:0] ptr_t;

endpackage

// ===== ptr_step.sv
// Purpose: next value of one pointer for a single step
// Assumes: pure combinational, used once per pointer
// Notes:   circular wrap only at the four region boundaries
`timescale 1ns/1ps
`include "dpau_defines.svh"

module ptr_step #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] cur,
    input  wire logic [7:0]   len,
    input  wire logic         dec,
    input  wire logic         circ,
    output logic      [W-1:0] nxt
);
    logic [W-1:0] a_top;
    logic [W-1:0] b_top;
    logic [W-1:0] a_base;
    logic [W-1:0] b_base;

    // region boundaries from the length register
    assign a_top  = W'({`REGION_A_HIGH, len});
    assign b_top  = W'({`REGION_B_HIGH, len});
    assign a_base = W'({`REGION_A_HIGH, 8'h00});
    assign b_base = W'({`REGION_B_HIGH, 8'h00});

    // wrap at boundaries, plain arithmetic elsewhere
    always_comb begin
        if (!dec) begin
            if (circ && cur == a_top) begin
                nxt = a_base;
            end else if (circ && cur == b_top) begin
                nxt = b_base;
            end else begin
                nxt = cur + W'(1);
            end
        end else begin
            if (circ && cur == a_base) begin
                nxt = a_top;
            end else if (circ && cur == b_base) begin
                nxt = b_top;
            end else begin
                nxt = cur - W'(1);
            end
        end
    end
endmodule

// ===== dual_pointer_address_unit.sv
// Purpose: two 16-bit data pointers with select, direction, auto-update,
//          redirect, index disable and circular wrap
// Assumes: decoder strobes OP_VALID for one cycle per pointer operation
// Notes:   memory request outputs appear one cycle after the operation
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "dpau_defines.svh"

module dual_pointer_address_unit
    import dpau_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // register port
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // decoder request
    input  wire logic        OP_VALID,
    input  wire logic [2:0]  OP_CODE,
    input  wire logic        OP_ALT,
    input  wire logic [15:0] OP_IMM,
    input  wire logic [7:0]  ACC,
    // memory request
    output logic             MEM_STB,
    output logic [15:0]      MEM_ADDR,
    output logic             MEM_WRITE,
    output logic             MEM_CODE,
    output logic             MEM_SIGNATURE,
    output logic             MEM_USE_B,
    output logic             JUMP_STB,
    output logic             IAP_SIGNATURE
);
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [7:0] pointer_config_q;
    logic [7:0] signal_processing_config_q;
    logic [7:0] circular_length_q;
    ptr_t       pointer_zero_q;
    ptr_t       pointer_one_q;
    ptr_t       step0;
    ptr_t       step1;
    ptr_t       sel_ptr;
    ptr_t       addr_d;
    op_e        op;
    logic       pointer_select;
    logic       ptr1_decrement;
    logic       ptr0_decrement;
    logic       ptr1_auto_update;
    logic       ptr0_auto_update;
    logic       signature_space_enable;
    logic       redirect_to_b;
    logic       code_index_disable;
    logic       ptr0_circular_enable;
    logic       ptr1_circular_enable;
    logic       use_one;
    logic       is_access;
    logic       step_zero;
    logic       step_one;
    logic [7:0] rdata_d;

    // reset release through two flip-flops
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // configuration fields
    assign pointer_select         = pointer_config_q[`BIT_POINTER_SELECT];
    assign ptr1_decrement         = pointer_config_q[`BIT_PTR1_DECREMENT];
    assign ptr0_decrement         = pointer_config_q[`BIT_PTR0_DECREMENT];
    assign ptr1_auto_update       = pointer_config_q[`BIT_PTR1_AUTO_UPDATE];
    assign ptr0_auto_update       = pointer_config_q[`BIT_PTR0_AUTO_UPDATE];
    assign signature_space_enable = pointer_config_q[`BIT_SIGNATURE_SPACE];
    assign redirect_to_b          = signal_processing_config_q[`BIT_REDIRECT_TO_B];
    assign code_index_disable     = signal_processing_config_q[`BIT_CODE_INDEX_DISABLE];
    assign ptr0_circular_enable   = signal_processing_config_q[`BIT_PTR0_CIRCULAR];
    assign ptr1_circular_enable   = signal_processing_config_q[`BIT_PTR1_CIRCULAR];

    // physical pointer choice; the jump ignores the prefix
    assign op      = op_e'(OP_CODE);
    assign use_one = pointer_select ^ (OP_ALT && op != OP_JMP);
    assign sel_ptr = use_one ? pointer_one_q : pointer_zero_q;
    assign is_access = (op == OP_XRD) || (op == OP_XWR) || (op == OP_CRD);

    // step requests: explicit increment or auto-update after access
    assign step_zero = OP_VALID && !use_one &&
                       (op == OP_INC || (is_access && ptr0_auto_update));
    assign step_one  = OP_VALID && use_one &&
                       (op == OP_INC || (is_access && ptr1_auto_update));

    // next values; direction bit picks increment or decrement
    ptr_step #(
        .W (16)
    ) u_step0 (
        .cur  (pointer_zero_q),
        .len  (circular_length_q),
        .dec  (ptr0_decrement),
        .circ (ptr0_circular_enable),
        .nxt  (step0)
    );

    ptr_step #(
        .W (16)
    ) u_step1 (
        .cur  (pointer_one_q),
        .len  (circular_length_q),
        .dec  (ptr1_decrement),
        .circ (ptr1_circular_enable),
        .nxt  (step1)
    );

    // pointer zero: decoder operations take priority over port writes
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pointer_zero_q <= `RST_POINTER;
        end else if (OP_VALID && op == OP_LOAD && !use_one) begin
            pointer_zero_q <= OP_IMM;
        end else if (step_zero) begin
            pointer_zero_q <= step0;
        end else if (REG_WR && REG_ADDR == `OFS_PTR0_LOW) begin
            pointer_zero_q[7:0] <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == `OFS_PTR0_HIGH) begin
            pointer_zero_q[15:8] <= REG_WDATA;
        end
    end

    // pointer one: same priority as pointer zero
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pointer_one_q <= `RST_POINTER;
        end else if (OP_VALID && op == OP_LOAD && use_one) begin
            pointer_one_q <= OP_IMM;
        end else if (step_one) begin
            pointer_one_q <= step1;
        end else if (REG_WR && REG_ADDR == `OFS_PTR1_LOW) begin
            pointer_one_q[7:0] <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == `OFS_PTR1_HIGH) begin
            pointer_one_q[15:8] <= REG_WDATA;
        end
    end

    // configuration registers; unused bits never store
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pointer_config_q           <= `RST_POINTER_CONFIG;
            signal_processing_config_q <= `RST_SIGNAL_PROC_CONFIG;
            circular_length_q          <= `RST_CIRCULAR_LENGTH;
        end else if (REG_WR) begin
            if (REG_ADDR == `OFS_POINTER_CONFIG) begin
                pointer_config_q <= REG_WDATA & `MASK_POINTER_CONFIG;
            end
            if (REG_ADDR == `OFS_SIGNAL_PROC_CONFIG) begin
                signal_processing_config_q <= REG_WDATA & `MASK_SIGNAL_PROC_CONFIG;
            end
            if (REG_ADDR == `OFS_CIRCULAR_LENGTH) begin
                circular_length_q <= REG_WDATA;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (REG_ADDR)
            `OFS_POINTER_CONFIG:     rdata_d = pointer_config_q;
            `OFS_SIGNAL_PROC_CONFIG: rdata_d = signal_processing_config_q;
            `OFS_CIRCULAR_LENGTH:    rdata_d = circular_length_q;
            `OFS_PTR0_LOW:           rdata_d = pointer_zero_q[7:0];
            `OFS_PTR0_HIGH:          rdata_d = pointer_zero_q[15:8];
            `OFS_PTR1_LOW:           rdata_d = pointer_one_q[7:0];
            `OFS_PTR1_HIGH:          rdata_d = pointer_one_q[15:8];
            default:                 rdata_d = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_d;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    // address: code read adds accumulator offset unless index disabled; jump always indexed; data moves unindexed
    always_comb begin
        if (op == OP_JMP || (op == OP_CRD && !code_index_disable)) begin
            addr_d = sel_ptr + ptr_t'(ACC);
        end else begin
            addr_d = sel_ptr;
        end
    end

    // memory request, one cycle after the operation, pre-update address
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            MEM_STB       <= 1'b0;
            MEM_ADDR      <= `RST_POINTER;
            MEM_WRITE     <= 1'b0;
            MEM_CODE      <= 1'b0;
            MEM_SIGNATURE <= 1'b0;
            MEM_USE_B     <= 1'b0;
            JUMP_STB      <= 1'b0;
        end else begin
            MEM_STB       <= OP_VALID && is_access;
            JUMP_STB      <= OP_VALID && op == OP_JMP;
            MEM_WRITE     <= OP_VALID && op == OP_XWR;
            MEM_CODE      <= OP_VALID && op == OP_CRD;
            MEM_SIGNATURE <= OP_VALID && op == OP_CRD && signature_space_enable;
            MEM_USE_B     <= OP_VALID && is_access && use_one && redirect_to_b;
            if (OP_VALID && (is_access || op == OP_JMP)) begin
                MEM_ADDR <= addr_d;
            end
        end
    end

    // programming accesses follow the signature bit
    always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            IAP_SIGNATURE <= 1'b0;
        end else begin
            IAP_SIGNATURE <= signature_space_enable;
        end
    end
endmodule

// ===== dpau_assertions.sv
// Purpose: port checks of the dual pointer address unit
// Assumes: raw NRST gates every check
// Notes:   pointer values are compared by the bench
`timescale 1ns/1ps
`include "dpau_defines.svh"
module dpau_assertions (
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       OP_VALID,
    input wire logic [2:0] OP_CODE,
    input wire logic       MEM_STB,
    input wire logic       MEM_WRITE,
    input wire logic       MEM_CODE,
    input wire logic       MEM_SIGNATURE,
    input wire logic       MEM_USE_B,
    input wire logic       JUMP_STB,
    input wire logic       IAP_SIGNATURE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // request steps reused below
    sequence cfg_wr; REG_WR && REG_ADDR == `OFS_POINTER_CONFIG; endsequence
    sequence cfg_rd; REG_RD && REG_ADDR == `OFS_POINTER_CONFIG; endsequence
    sequence spc_rd; REG_RD && REG_ADDR == `OFS_SIGNAL_PROC_CONFIG; endsequence
    sequence op_is(logic [2:0] c); OP_VALID && OP_CODE == c; endsequence
    sig_level_a: assert property (cfg_wr ##1 !REG_WR |=> IAP_SIGNATURE == $past(REG_WDATA[3], 2))
        else $error("signature level does not follow config");
    cfg_fixed_a: assert property (cfg_rd |=> REG_RDATA[2:1] == 2'b00)
        else $error("fixed config bits read nonzero");
    spc_fixed_a: assert property (spc_rd |=> REG_RDATA[7:4] == 4'h0)
        else $error("unused mode bits read nonzero");
    write_req_a: assert property (op_is(3'h3) |=> MEM_STB && MEM_WRITE && !MEM_CODE)
        else $error("write move gave wrong request");
    code_req_a: assert property (op_is(3'h4) |=> MEM_STB && MEM_CODE && !MEM_WRITE)
        else $error("code read gave wrong request");
    jump_req_a: assert property (op_is(3'h5) |=> JUMP_STB && !MEM_STB)
        else $error("jump gave wrong request");
    step_quiet_a: assert property (OP_VALID && OP_CODE <= 3'h1 |=> !MEM_STB && !JUMP_STB)
        else $error("load or step made a request");
    idle_quiet_a: assert property (!OP_VALID |=> !MEM_STB && !JUMP_STB)
        else $error("request without operation");
    sig_code_a: assert property (MEM_SIGNATURE |-> MEM_CODE && MEM_STB)
        else $error("signature flag outside code read");
    b_xfer_a: assert property (MEM_USE_B |-> MEM_STB && !JUMP_STB)
        else $error("B flag outside a transfer");
endmodule
bind dual_pointer_address_unit dpau_assertions chk (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .MEM_STB(MEM_STB),
    .MEM_WRITE(MEM_WRITE), .MEM_CODE(MEM_CODE), .MEM_SIGNATURE(MEM_SIGNATURE),
    .MEM_USE_B(MEM_USE_B), .JUMP_STB(JUMP_STB), .IAP_SIGNATURE(IAP_SIGNATURE));

// ===== mem_port_model.sv
// Purpose: memory side of the address unit
// Assumes: requests are one-cycle pulses
// Notes:   keeps only a request count and the latest address
`timescale 1ns/1ps
module mem_port_model (
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic        MEM_STB,
    input  wire logic [15:0] MEM_ADDR,
    output logic      [7:0]  hits_q,
    output logic      [15:0] last_q
);
    // count requests and keep the latest address
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            hits_q <= 8'h00;
            last_q <= 16'h0000;
        end else if (MEM_STB === 1'b1) begin
            hits_q <= hits_q + 8'h01;
            last_q <= MEM_ADDR;
        end
    end
endmodule

// ===== dual_pointer_address_unit_bench.sv
// Purpose: self-checking bench of the dual pointer address unit
// Assumes: rows run in order, each row leaves pointer state for the next
// Notes:   row = cfg, mode, {alt,op}, acc, imm or address, request flags
`timescale 1ns/1ps
module dual_pointer_address_unit_bench;
    logic        SYS_CLK = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    logic        OP_VALID = 1'b0, OP_ALT = 1'b0;
    logic [7:0]  REG_ADDR = 8'h00, REG_WDATA = 8'h00, ACC = 8'h00, REG_RDATA, hits;
    logic [2:0]  OP_CODE = 3'h0;
    logic [15:0] OP_IMM = 16'h0000, MEM_ADDR, last;
    logic        MEM_STB, MEM_WRITE, MEM_CODE, MEM_SIGNATURE, MEM_USE_B, JUMP_STB;
    logic        IAP_SIGNATURE;
    logic [51:0] r;
    int          bad_count = 0, samples_checked = 0;
    wire  [7:0]  fl = {2'b00, MEM_STB, MEM_WRITE, MEM_CODE, MEM_SIGNATURE, MEM_USE_B, JUMP_STB};
    logic [51:0] rows [21] = '{
        52'h0_0000_0000_0500, 52'h0_0041_0000_0000, 52'h0_0042_0000_0020,
        52'h1_0041_0000_0000, 52'h0_0042_0000_0520, 52'h4_0042_0000_0520,
        52'h4_0042_0000_0020, 52'h0_1008_0001_0000, 52'h0_1000_0001_0500,
        52'h0_1081_0000_0000, 52'h0_1093_0001_0032, 52'h2_1081_0000_0000,
        52'h0_101A_0001_0020, 52'h0_1049_0000_0000, 52'h0_1041_0000_0000,
        52'h0_1042_0001_0620, 52'h0_801C_1001_162E, 52'h0_0024_1001_0128,
        52'h0_102D_1001_1601, 52'h2_0009_0000_0000, 52'h0_000A_0001_0520};
    dual_pointer_address_unit DUT (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_ALT(OP_ALT), .OP_IMM(OP_IMM), .ACC(ACC),
        .MEM_STB(MEM_STB), .MEM_ADDR(MEM_ADDR), .MEM_WRITE(MEM_WRITE), .MEM_CODE(MEM_CODE),
        .MEM_SIGNATURE(MEM_SIGNATURE), .MEM_USE_B(MEM_USE_B), .JUMP_STB(JUMP_STB),
        .IAP_SIGNATURE(IAP_SIGNATURE));
    mem_port_model mem (.SYS_CLK(SYS_CLK), .NRST(NRST), .MEM_STB(MEM_STB),
        .MEM_ADDR(MEM_ADDR), .hits_q(hits), .last_q(last));
    // free-running 125 MHz clock
    always #4 SYS_CLK = ~SYS_CLK;
    // value comparison with mismatch report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    // one-cycle register read, data checked in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        chk({8'h00, REG_RDATA}, {8'h00, exp});
    endtask
    // one decoder operation, returns while its request stands
    task automatic op(input logic [3:0] o, input logic [7:0] a, input logic [15:0] v);
        @(posedge SYS_CLK);
        OP_VALID <= 1'b1;
        OP_ALT <= o[3];
        OP_CODE <= o[2:0];
        ACC <= a;
        OP_IMM <= v;
        @(posedge SYS_CLK);
        OP_VALID <= 1'b0;
        #1;
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run
    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        rd(8'hA2, 8'h00);
        rd(8'hE2, 8'h00);
        rd(8'hE3, 8'h00);
        wr(8'hE3, 8'h05);
        rd(8'hE3, 8'h05);
        $display("test reset values done");
        foreach (rows[i]) begin
            r = rows[i];
            wr(8'hA2, r[51:44]);
            wr(8'hE2, r[43:36]);
            op(r[35:32], r[31:24], r[23:8]);
            chk({8'h00, fl}, {8'h00, r[7:0]});
            if (r[7:0] != 8'h00) chk(MEM_ADDR, r[23:8]);
        end
        $display("test operation rows done");
        // full 256-entry region, auto-update wraps at the top
        wr(8'hE3, 8'hFF);
        wr(8'hA2, 8'h40);
        wr(8'hE2, 8'h04);
        op(4'h0, 8'h00, 16'h00FF);
        op(4'h2, 8'h00, 16'h0000);
        chk(MEM_ADDR, 16'h00FF);
        op(4'h2, 8'h00, 16'h0000);
        chk(MEM_ADDR, 16'h0000);
        // the model counts the last request one edge after it appears
        @(posedge SYS_CLK);
        #1;
        chk({8'h00, hits}, 16'h000C);
        chk(last, 16'h0000);
        rd(8'hC4, 8'h01);
        rd(8'hC6, 8'h05);
        rd(8'hC7, 8'h01);
        // port-written pointer carries into its high byte when not circular
        wr(8'hE2, 8'h00);
        wr(8'hC4, 8'hFF);
        op(4'h1, 8'h00, 16'h0000);
        rd(8'hC5, 8'h01);
        rd(8'hC4, 8'h00);
        $display("test full region done");
        // fixed bits, unmapped place, signature level
        wr(8'hA2, 8'hFF);
        rd(8'hA2, 8'hF9);
        chk({15'h0000, IAP_SIGNATURE}, 16'h0001);
        wr(8'hE2, 8'hFF);
        rd(8'hE2, 8'h0F);
        rd(8'h00, 8'h00);
        $display("test fixed bits done");
        // reset in mid-run clears the configuration
        @(posedge SYS_CLK);
        NRST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        rd(8'hA2, 8'h00);
        chk({15'h0000, IAP_SIGNATURE}, 16'h0000);
        rd(8'hE3, 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
